// ===== rtl/pbmc_defs.vh
// constants for the phy basic mode control block
`ifndef PBMC_DEFS_VH
`define PBMC_DEFS_VH
`define PBMC_CTRL_ADDR 12'h000
`define PBMC_AUX_ADDR 12'h004
`define PBMC_RESET_VAL 16'h3100
`define PBMC_RSVD_MASK 16'h007f
`define PBMC_B_RESET 15
`define PBMC_B_LOOP 14
`define PBMC_B_SPEED 13
`define PBMC_B_ANEN 12
`define PBMC_B_PDOWN 11
`define PBMC_B_ISO 10
`define PBMC_B_RESTART 9
`define PBMC_B_DUPLEX 8
`define PBMC_B_COLTEST 7
`define PBMC_RESP_OKAY 2'h0
`define PBMC_RESP_SLVERR 2'h2
`define PBMC_DEAD_MS 720
`define PBMC_CLK_KHZ 40000
`define PBMC_RST_CYC 16
`endif

// ===== rtl/pbmc_sync.v
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/10ps
module pbmc_sync #(
    parameter W = 1
) (
    input wire ref_clk,
    input wire srst,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] s1Q;
    reg [W-1:0] s2Q;
    reg [W-1:0] s3Q;
    integer i;
    always @(posedge ref_clk) begin
        if (srst) begin
            s1Q <= {W{1'b0}};
            s2Q <= {W{1'b0}};
            s3Q <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            s1Q <= din;
            s2Q <= s1Q;
            s3Q <= s2Q;
            for (i = 0; i < W; i = i + 1) begin
                if (s2Q[i] == s3Q[i]) begin
                    dout[i] <= s3Q[i];
                end
            end
        end
    end
endmodule

// ===== rtl/pbmc_timer.v
// down counter giving a busy level while a loaded count runs
`timescale 1ns/10ps
module pbmc_timer #(
    parameter W = 32
) (
    input wire ref_clk,
    input wire srst,
    input wire load,
    input wire [W-1:0] count,
    output wire busy
);
    reg [W-1:0] cntQ;
    assign busy = (cntQ != {W{1'b0}});
    always @(posedge ref_clk) begin
        if (srst) begin
            cntQ <= {W{1'b0}};
        end else if (load) begin
            cntQ <= count;
        end else if (busy) begin
            cntQ <= cntQ - {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule

// ===== rtl/pbmc_top.v
// basic mode control register of a 10/100 phy behind axi4-lite
`timescale 1ns/10ps
`include "pbmc_defs.vh"
module pbmc_top #(
    parameter DEAD_CYC = `PBMC_DEAD_MS * `PBMC_CLK_KHZ,
    parameter RST_CYC = `PBMC_RST_CYC
) (
    input wire ref_clk,
    input wire srst,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire anegStarted,
    input wire anegSpeed100,
    input wire anegFullDuplex,
    input wire txActive,
    input wire descramLocked,
    output reg loopbackEn,
    output reg speed100,
    output reg fullDuplex,
    output reg anegEnable,
    output reg powerDown,
    output reg isolate,
    output reg anegRestart,
    output reg collision,
    output reg rxDeadTime,
    output reg phyResetBusy
);
    reg [15:0] ctrlQ;
    reg [15:0] ctrlD;
    reg awHeldQ;
    reg [11:0] awAddrQ;
    reg wHeldQ;
    reg [31:0] wDataQ;
    reg [3:0] wStrbQ;
    reg restartPendQ;
    reg deadArmQ;
    reg lockPrevQ;
    wire [2:0] syncIn;
    wire [2:0] syncOut;
    wire startedS;
    wire lockedS;
    wire txS;
    wire doWrite;
    wire wrHit;
    wire rstBusy;
    wire deadBusy;
    wire swReset;
    wire deadLoad;
    wire [15:0] wrVal;

    // link-side status comes from the phy clock-free core domain
    assign syncIn = {anegStarted, descramLocked, txActive};
    pbmc_sync #(.W(3)) uSync (
        .ref_clk(ref_clk),
        .srst(srst),
        .din(syncIn),
        .dout(syncOut)
    );
    assign startedS = syncOut[2];
    assign lockedS = syncOut[1];
    assign txS = syncOut[0];

    function [15:0] readView;
        input [15:0] c;
        input an;
        input spd;
        input dup;
        reg [15:0] v;
        begin
            v = c & ~`PBMC_RSVD_MASK;
            if (an) begin
                v[`PBMC_B_SPEED] = spd;
                v[`PBMC_B_DUPLEX] = dup;
            end
            readView = v;
        end
    endfunction

    // register decode on word address
    function addrIsCtrl;
        input [11:0] a;
        begin
            addrIsCtrl = ((a >> 2) == (`PBMC_CTRL_ADDR >> 2));
        end
    endfunction

    function addrIsAux;
        input [11:0] a;
        begin
            addrIsAux = ((a >> 2) == (`PBMC_AUX_ADDR >> 2));
        end
    endfunction

    assign s_axi_awready = !awHeldQ && !s_axi_bvalid;
    assign s_axi_wready = !wHeldQ && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign doWrite = awHeldQ && wHeldQ && !s_axi_bvalid;
    assign wrHit = doWrite && addrIsCtrl(awAddrQ);
    assign wrVal = wDataQ[15:0];
    assign swReset = wrHit && wStrbQ[1] && wrVal[`PBMC_B_RESET];

    pbmc_timer #(.W(8)) uRstTmr (
        .ref_clk(ref_clk),
        .srst(srst),
        .load(swReset),
        .count(RST_CYC[7:0]),
        .busy(rstBusy)
    );

    // loss of descrambler lock under loop-back at 100
    assign deadLoad = deadArmQ && lockPrevQ && !lockedS;
    pbmc_timer #(.W(32)) uDeadTmr (
        .ref_clk(ref_clk),
        .srst(srst),
        .load(deadLoad),
        .count(DEAD_CYC[31:0]),
        .busy(deadBusy)
    );

    always @* begin
        ctrlD = ctrlQ;
        if (swReset) begin
            ctrlD = `PBMC_RESET_VAL;
            ctrlD[`PBMC_B_RESET] = 1'b1;
        end else if (wrHit) begin
            if (wStrbQ[0]) begin
                ctrlD[7:0] = wrVal[7:0];
            end
            if (wStrbQ[1]) begin
                ctrlD[15:8] = wrVal[15:8];
            end
            if (wStrbQ[1] && !wrVal[`PBMC_B_RESTART] && restartPendQ) begin
                ctrlD[`PBMC_B_RESTART] = 1'b1;
            end
            if (!ctrlD[`PBMC_B_ANEN]) begin
                ctrlD[`PBMC_B_RESTART] = 1'b0;
            end
        end
        if (ctrlQ[`PBMC_B_RESET] && !rstBusy && !swReset) begin
            ctrlD[`PBMC_B_RESET] = 1'b0;
        end
        if (restartPendQ && startedS) begin
            ctrlD[`PBMC_B_RESTART] = 1'b0;
        end
        ctrlD = ctrlD & ~`PBMC_RSVD_MASK;
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            ctrlQ <= `PBMC_RESET_VAL;
            restartPendQ <= 1'b0;
            deadArmQ <= 1'b0;
            lockPrevQ <= 1'b0;
        end else begin
            ctrlQ <= ctrlD;
            // restart request held to the engine
            if (ctrlD[`PBMC_B_RESTART] && ctrlD[`PBMC_B_ANEN] && !startedS) begin
                restartPendQ <= 1'b1;
            end else if (startedS || !ctrlD[`PBMC_B_ANEN] || swReset) begin
                restartPendQ <= 1'b0;
            end
            // arm dead time at 100 in loop-back
            deadArmQ <= ctrlQ[`PBMC_B_LOOP] && speed100;
            lockPrevQ <= lockedS;
        end
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            loopbackEn <= 1'b0;
            speed100 <= 1'b1;
            fullDuplex <= 1'b1;
            anegEnable <= 1'b1;
            powerDown <= 1'b0;
            isolate <= 1'b0;
            anegRestart <= 1'b0;
            collision <= 1'b0;
            rxDeadTime <= 1'b0;
            phyResetBusy <= 1'b0;
        end else begin
            loopbackEn <= ctrlQ[`PBMC_B_LOOP];
            speed100 <= ctrlQ[`PBMC_B_ANEN] ? anegSpeed100 : ctrlQ[`PBMC_B_SPEED];
            // written duplex only with autoneg off
            fullDuplex <= ctrlQ[`PBMC_B_ANEN] ? anegFullDuplex : ctrlQ[`PBMC_B_DUPLEX];
            anegEnable <= ctrlQ[`PBMC_B_ANEN];
            powerDown <= ctrlQ[`PBMC_B_PDOWN];
            isolate <= ctrlQ[`PBMC_B_ISO];
            anegRestart <= restartPendQ;
            collision <= ctrlQ[`PBMC_B_COLTEST] && txS;
            rxDeadTime <= deadBusy;
            phyResetBusy <= ctrlQ[`PBMC_B_RESET];
        end
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            awHeldQ <= 1'b0;
            awAddrQ <= 12'h000;
            wHeldQ <= 1'b0;
            wDataQ <= 32'h00000000;
            wStrbQ <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PBMC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeldQ <= 1'b1;
                awAddrQ <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeldQ <= 1'b1;
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeldQ <= 1'b0;
                wHeldQ <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (addrIsCtrl(awAddrQ)) begin
                    s_axi_bresp <= `PBMC_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `PBMC_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PBMC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `PBMC_RESP_OKAY;
            if (addrIsCtrl(s_axi_araddr)) begin
                // negotiated speed and duplex read back with autoneg on, written values with it off
                s_axi_rdata <= {16'h0000, readView(ctrlQ, ctrlQ[`PBMC_B_ANEN],
                    anegSpeed100, anegFullDuplex)};
            end else if (addrIsAux(s_axi_araddr)) begin
                s_axi_rdata <= {29'h00000000, deadBusy, restartPendQ, rstBusy};
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `PBMC_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ===== dv/pbmc_monitor.sv
// checker on the mode control ports
`timescale 1ns/10ps
module pbmc_monitor (
    input wire ref_clk,
    input wire srst,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire [31:0] s_axi_rdata,
    input wire anegSpeed100,
    input wire anegFullDuplex,
    input wire speed100,
    input wire fullDuplex,
    input wire anegEnable,
    input wire anegRestart,
    input wire powerDown,
    input wire phyResetBusy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    chk_speed_follows_aneg: assert property (!$past(srst) && anegEnable && $past(anegEnable)
        && $stable(anegSpeed100) |-> speed100 == anegSpeed100) else $error("speed not negotiated");
    chk_duplex_follows_aneg: assert property (!$past(srst) && anegEnable && $past(anegEnable)
        && $stable(anegFullDuplex) |-> fullDuplex == anegFullDuplex) else $error("duplex wrong");
    chk_reset_bit_holds: assert property ($rose(phyResetBusy) |-> phyResetBusy[*8])
        else $error("reset bit cleared early");
    chk_reset_bit_ends: assert property ($rose(phyResetBusy) |-> ##[1:40] !phyResetBusy)
        else $error("reset bit stuck");
    chk_restart_clears: assert property ($rose(anegRestart) |-> ##[1:60] !anegRestart)
        else $error("restart stuck");
    chk_restart_inert: assert property (!anegEnable && !$past(anegRestart) |-> !anegRestart)
        else $error("restart with aneg off");
    chk_powerdown_answers: assert property (powerDown && s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("no answer in power down");
    chk_reserved_zero: assert property (s_axi_rvalid |-> s_axi_rdata[6:3] == 4'h0)
        else $error("reserved bits set");
endmodule
bind pbmc_top pbmc_monitor pbmc_monitor_inst (.ref_clk, .srst, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rdata, .anegSpeed100, .anegFullDuplex, .speed100, .fullDuplex,
    .anegEnable, .anegRestart, .powerDown, .phyResetBusy);

// ===== dv/pbmc_aneg_model.sv
// negotiation engine model answering restart requests
`timescale 1ns/10ps
module pbmc_aneg_model (
    input wire ref_clk,
    input wire srst,
    input wire anegRestart,
    input wire [3:0] dly,
    output logic anegStarted
);
    logic [3:0] cnt_q;
    // start flag dly+1 cycles after request, drops with request
    always @(posedge ref_clk) begin
        if (srst || !anegRestart) begin
            cnt_q <= 4'h0;
            anegStarted <= 1'h0;
        end else if (cnt_q == dly) begin
            anegStarted <= 1'h1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

// ===== dv/pbmc_top_tb_top.sv
// testbench for the mode control register block
`timescale 1ns/10ps
`include "pbmc_defs.vh"
module pbmc_top_tb_top;
    localparam logic [11:0] CA = `PBMC_CTRL_ADDR;
    localparam logic [1:0] OK = `PBMC_RESP_OKAY;
    localparam logic [1:0] SE = `PBMC_RESP_SLVERR;
    logic ref_clk = 1'h0, srst = 1'h1, txActive = 1'h0, descramLocked = 1'h1;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, anegSpeed100 = 1'h1, anegFullDuplex = 1'h1;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, dly = 4'h9;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, anegStarted;
    logic loopbackEn, speed100, fullDuplex, anegEnable, powerDown, isolate, anegRestart;
    logic collision, rxDeadTime, phyResetBusy;
    int error_cnt = 0, n_compared = 0, n;
    always #12.5 ref_clk = ~ref_clk;
    pbmc_top #(.DEAD_CYC(20)) pbmc_top_inst (.ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .anegStarted, .anegSpeed100,
        .anegFullDuplex, .txActive, .descramLocked, .loopbackEn, .speed100, .fullDuplex,
        .anegEnable, .powerDown, .isolate, .anegRestart, .collision, .rxDeadTime, .phyResetBusy);
    pbmc_aneg_model pbmc_aneg_model_inst (.ref_clk, .srst, .anegRestart, .dly, .anegStarted);
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task cb(input string nm, input logic s, input logic e);
        chk(nm, {31'h0, s}, {31'h0, e});
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) break;
        end
        s_axi_bready <= 1'h0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) break;
        end
        s_axi_rready <= 1'h0;
        chk("rdata", s_axi_rdata, e);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    task t_dflt;
        rd(CA, `PBMC_RESET_VAL, OK);
        cb("anegEnable", anegEnable, 1'h1);
        cb("isolate", isolate, 1'h0);
        $display("t_dflt end");
    endtask
    task t_manual;
        wr(CA, 32'h0, OK);
        rd(CA, 32'h0, OK);
        cb("speed100", speed100, 1'h0);
        cb("fullDuplex", fullDuplex, 1'h0);
        wr(CA, 32'h0200, OK);
        rd(CA, 32'h0, OK);
        wr(CA, 32'h61ff, OK);
        rd(CA, 32'h6180, OK);
        cb("loopbackEn", loopbackEn, 1'h1);
        txActive <= 1'h1;
        repeat (6) @(posedge ref_clk);
        cb("collision", collision, 1'h1);
        txActive <= 1'h0;
        repeat (6) @(posedge ref_clk);
        cb("collision", collision, 1'h0);
        wr(CA, 32'h0800, OK);
        rd(CA, 32'h0800, OK);
        cb("powerDown", powerDown, 1'h1);
        $display("t_manual end");
    endtask
    task t_dead;
        wr(CA, 32'h6000, OK);
        descramLocked <= 1'h0;
        repeat (8) @(posedge ref_clk);
        cb("rxDeadTime", rxDeadTime, 1'h1);
        repeat (30) @(posedge ref_clk);
        cb("rxDeadTime", rxDeadTime, 1'h0);
        descramLocked <= 1'h1;
        $display("t_dead end");
    endtask
    task t_swrst;
        wr(CA, 32'h8000, OK);
        rd(CA, 32'hb100, OK);
        rd(`PBMC_AUX_ADDR, 32'h1, OK);
        repeat (30) @(posedge ref_clk);
        rd(CA, `PBMC_RESET_VAL, OK);
        rd(`PBMC_AUX_ADDR, 32'h0, OK);
        cb("loopbackEn", loopbackEn, 1'h0);
        $display("t_swrst end");
    endtask
    task t_aneg;
        anegSpeed100 <= 1'h0;
        anegFullDuplex <= 1'h0;
        rd(CA, 32'h1000, OK);
        cb("speed100", speed100, 1'h0);
        cb("fullDuplex", fullDuplex, 1'h0);
        wr(CA, 32'h1200, OK);
        wr(CA, 32'h1000, OK);
        cb("anegRestart", anegRestart, 1'h1);
        rd(CA, 32'h1200, OK);
        for (n = 0; n < 40 && anegStarted !== 1'h1; n++) @(posedge ref_clk);
        cb("anegStarted", anegStarted, 1'h1);
        repeat (8) @(posedge ref_clk);
        cb("anegRestart", anegRestart, 1'h0);
        dly <= 4'h1;
        wr(CA, 32'h1200, OK);
        repeat (12) @(posedge ref_clk);
        rd(CA, 32'h1000, OK);
        $display("t_aneg end");
    endtask
    task t_unmap;
        rd(12'h008, 32'h0, SE);
        wr(12'h008, 32'h0000_1234, SE);
        rd(CA, 32'h1000, OK);
        $display("t_unmap end");
    endtask
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        srst <= 1'h0;
        t_dflt;
        t_manual;
        t_dead;
        t_swrst;
        t_aneg;
        t_unmap;
        summarize;
    end
    initial begin
        #200000;
        error_cnt++;
        summarize;
    end
endmodule
